// file: ocpcl_regs.vh
// Register map, field layout and timing constants of the clock-source block
`ifndef OCPCL_REGS_VH
`define OCPCL_REGS_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define OCPCL_ADDR_W          12
`define OCPCL_OFS_RUNCFG      12'h060
`define OCPCL_OFS_XLATE       12'h064
`define OCPCL_OFS_STATUS      12'h068

// ----------------------------------------------------------------------
// Run clock configuration fields
// ----------------------------------------------------------------------
`define OCPCL_MAIN_OFF_BIT    0
`define OCPCL_INT_OFF_BIT     1
`define OCPCL_MAIN_CHK_BIT    2
`define OCPCL_INT_CHK_BIT     3
`define OCPCL_SRC_LO          4
`define OCPCL_SRC_HI          5
`define OCPCL_CRYSTAL_SELECT_LO         6
`define OCPCL_CRYSTAL_SELECT_HI         9
`define OCPCL_PLL_CHK_BIT     10
`define OCPCL_BYPASS_BIT      11
`define OCPCL_GATE_N_BIT      12
`define OCPCL_PLL_POWER_DOWN_BIT       13
`define OCPCL_RUNCFG_W        14
`define OCPCL_RUNCFG_RST      14'h3AC0

// Oscillator source codes
`define OCPCL_SRC_MAIN        2'h0
`define OCPCL_SRC_INT         2'h1
`define OCPCL_SRC_INT_DIV4    2'h2
`define OCPCL_SRC_RSVD        2'h3

// Crystal codes
`define OCPCL_CRYSTAL_SELECT_RST        4'hB
`define OCPCL_CRYSTAL_SELECT_FIRST      4'h4

// ----------------------------------------------------------------------
// Translation fields and values loaded by reset (6 MHz entry)
// ----------------------------------------------------------------------
`define OCPCL_OD_LO           14
`define OCPCL_OD_HI           15
`define OCPCL_F_LO            5
`define OCPCL_F_HI            13
`define OCPCL_R_LO            0
`define OCPCL_R_HI            4
`define OCPCL_OD_RST          2'h0
`define OCPCL_F_RST           9'h0C8
`define OCPCL_R_RST           5'h03

// ----------------------------------------------------------------------
// Status fields and checker timing
// ----------------------------------------------------------------------
`define OCPCL_FLT_MAIN        0
`define OCPCL_FLT_INT         1
`define OCPCL_FLT_PLL         2
`define OCPCL_NCHK            3
`define OCPCL_CLK_MHZ         200
`define OCPCL_CHK_TIMEOUT_NS  1000
`define OCPCL_CHK_CYCLES      ((`OCPCL_CHK_TIMEOUT_NS * `OCPCL_CLK_MHZ + 999) / 1000)
`define OCPCL_CNT_W           8

`endif

// file: ocpcl_xlate.v
// Crystal code to PLL divider lookup table
`default_nettype none

module ocpcl_xlate
(
	input  wire [3:0] xtalCode,
	output reg  [1:0] outDiv,
	output reg  [8:0] feedback,
	output reg  [4:0] refDiv
);

// ----------------------------------------------------------------------
// Fixed table aimed at a 400 MHz PLL output
// ----------------------------------------------------------------------
// fixed divider table
always @*
begin
	outDiv = 2'h0;
	case (xtalCode)
		4'h4:    begin feedback = 9'h070; refDiv = 5'h01; end
		4'h5:    begin feedback = 9'h06D; refDiv = 5'h01; end
		4'h6:    begin feedback = 9'h064; refDiv = 5'h01; end
		4'h7:    begin feedback = 9'h062; refDiv = 5'h01; end
		4'h8:    begin feedback = 9'h051; refDiv = 5'h01; end
		4'h9:    begin feedback = 9'h050; refDiv = 5'h01; end
		4'hA:    begin feedback = 9'h04E; refDiv = 5'h01; end
		4'hB:    begin feedback = 9'h0C8; refDiv = 5'h03; end
		4'hC:    begin feedback = 9'h041; refDiv = 5'h01; end
		4'hD:    begin feedback = 9'h036; refDiv = 5'h01; end
		4'hE:    begin feedback = 9'h032; refDiv = 5'h01; end
		4'hF:    begin feedback = 9'h031; refDiv = 5'h01; end
		default: begin feedback = 9'h000; refDiv = 5'h00; end
	endcase
end

endmodule // ocpcl_xlate

`default_nettype wire

// file: ocpcl_watch.v
// Verification timer for one clock source
`default_nettype none
`include "ocpcl_regs.vh"

module ocpcl_watch
(
	input  wire clk,
	input  wire nrst,
	input  wire enable,
	input  wire aliveTick,
	output reg  fault
);

reg [`OCPCL_CNT_W-1:0] idleCount;

// ----------------------------------------------------------------------
// Count cycles without a tick; pulse fault at the timeout
// ----------------------------------------------------------------------
always @(posedge clk or negedge nrst)
begin
	if (!nrst)
	begin
		idleCount <= {`OCPCL_CNT_W{1'b0}};
		fault     <= 1'b0;
	end
	else if (!enable || aliveTick)
	begin
		idleCount <= {`OCPCL_CNT_W{1'b0}};
		fault     <= 1'b0;
	end
	else if (idleCount == `OCPCL_CHK_CYCLES - 1)
	begin
		// Restart so a dead source keeps reporting each period
		idleCount <= {`OCPCL_CNT_W{1'b0}};
		fault     <= 1'b1;
	end
	else
	begin
		idleCount <= idleCount + 1'b1;
		fault     <= 1'b0;
	end
end

endmodule // ocpcl_watch

`default_nettype wire

// file: ocpcl_top.v
// Clock-source configuration: run clock register, PLL decode, translation
//
// Design decision made here: the strobed register port.
`default_nettype none
`include "ocpcl_regs.vh"

module ocpcl_top
(
	input  wire                     clk,
	input  wire                     nrst,
	input  wire [`OCPCL_ADDR_W-1:0] regAddr,
	input  wire [31:0]              regWdata,
	input  wire                     regWr,
	input  wire                     regRd,
	output reg  [31:0]              regRdata,
	input  wire                     mainOscTick,
	input  wire                     intOscTick,
	input  wire                     pllTick,
	output reg                      mainOscOff,
	output reg                      intOscOff,
	output reg  [1:0]               oscSourceSel,
	output reg                      pllPowerDown,
	output reg                      pllOutGateN,
	output reg                      pllRunning,
	output reg                      sysClkFromOsc,
	output reg  [1:0]               pllOutDividerIn,
	output reg  [8:0]               pllFeedback,
	output reg  [4:0]               pllRefDiv,
	output reg  [`OCPCL_NCHK-1:0]   clkFault,
	output reg                      clkFailIrq
);

// ----------------------------------------------------------------------
// Declarations
// ----------------------------------------------------------------------
reg  [`OCPCL_RUNCFG_W-1:0] runCfg;
reg  [`OCPCL_RUNCFG_W-1:0] next_runCfg;
reg  [3:0]                 xtalSeen;
reg                        loadPending;
reg  [`OCPCL_NCHK-1:0]     next_clkFault;
reg  [31:0]                next_regRdata;
wire [1:0]                 lutOutDiv;
wire [8:0]                 lutFeedback;
wire [4:0]                 lutRefDiv;
wire [`OCPCL_NCHK-1:0]     checkEn;
wire [`OCPCL_NCHK-1:0]     aliveTick;
wire [`OCPCL_NCHK-1:0]     faultPulse;
wire                       wrRunCfg;
wire                       wrStatus;
wire [3:0]                 xtalNow;
wire                       xlateReload;
wire [31:0]                runCfgWord;
wire [31:0]                xlateWord;
wire [31:0]                statusWord;

// ----------------------------------------------------------------------
// Register write decode
// ----------------------------------------------------------------------
assign wrRunCfg = regWr && (regAddr == `OCPCL_OFS_RUNCFG);
assign wrStatus = regWr && (regAddr == `OCPCL_OFS_STATUS);
assign xtalNow  = runCfg[`OCPCL_CRYSTAL_SELECT_HI:`OCPCL_CRYSTAL_SELECT_LO];

// ----------------------------------------------------------------------
// Run clock configuration register
// ----------------------------------------------------------------------
always @*
begin
	next_runCfg = runCfg;
	if (wrRunCfg)
	begin
		next_runCfg = regWdata[`OCPCL_RUNCFG_W-1:0];
		if (regWdata[`OCPCL_SRC_HI:`OCPCL_SRC_LO] == `OCPCL_SRC_RSVD)
			next_runCfg[`OCPCL_SRC_HI:`OCPCL_SRC_LO] =
				runCfg[`OCPCL_SRC_HI:`OCPCL_SRC_LO];
	end
end

always @(posedge clk or negedge nrst)
begin
	if (!nrst)
		runCfg <= `OCPCL_RUNCFG_RST;
	else
		runCfg <= next_runCfg;
end

// ----------------------------------------------------------------------
// Oscillator control outputs
// ----------------------------------------------------------------------
always @(posedge clk or negedge nrst)
begin
	if (!nrst)
	begin
		mainOscOff   <= 1'b0;
		intOscOff    <= 1'b0;
		oscSourceSel <= `OCPCL_SRC_MAIN;
	end
	else
	begin
		mainOscOff   <= runCfg[`OCPCL_MAIN_OFF_BIT];
		intOscOff    <= runCfg[`OCPCL_INT_OFF_BIT];
		oscSourceSel <= runCfg[`OCPCL_SRC_HI:`OCPCL_SRC_LO];
	end
end

// ----------------------------------------------------------------------
// PLL power and output gate
// ----------------------------------------------------------------------
always @(posedge clk or negedge nrst)
begin
	if (!nrst)
	begin
		pllPowerDown <= 1'b1;
		pllOutGateN  <= 1'b1;
	end
	else
	begin
		pllPowerDown <= runCfg[`OCPCL_PLL_POWER_DOWN_BIT];
		pllOutGateN  <= runCfg[`OCPCL_GATE_N_BIT];
	end
end

// ----------------------------------------------------------------------
// PLL mode decode
// ----------------------------------------------------------------------
always @(posedge clk or negedge nrst)
begin
	if (!nrst)
		pllRunning <= 1'b0;
	else
		pllRunning <= !runCfg[`OCPCL_PLL_POWER_DOWN_BIT] &&
			!runCfg[`OCPCL_GATE_N_BIT];
end

// ----------------------------------------------------------------------
// System clock path selection
// ----------------------------------------------------------------------
always @(posedge clk or negedge nrst)
begin
	if (!nrst)
		sysClkFromOsc <= 1'b1;
	else
		sysClkFromOsc <= runCfg[`OCPCL_BYPASS_BIT];
end

// ----------------------------------------------------------------------
// Crystal to PLL translation register
// ----------------------------------------------------------------------
ocpcl_xlate xlate
(
	.xtalCode (xtalNow),
	.outDiv   (lutOutDiv),
	.feedback (lutFeedback),
	.refDiv   (lutRefDiv)
);

// ----------------------------------------------------------------------
// Translation reload: first cycle after reset or crystal change
// ----------------------------------------------------------------------
assign xlateReload = loadPending || (xtalNow != xtalSeen);

always @(posedge clk or negedge nrst)
begin
	if (!nrst)
	begin
		xtalSeen    <= `OCPCL_CRYSTAL_SELECT_RST;
		loadPending <= 1'b1;
	end
	else
	begin
		xtalSeen    <= xtalNow;
		loadPending <= 1'b0;
	end
end

// ----------------------------------------------------------------------
// Translation fields driving the PLL
// ----------------------------------------------------------------------
always @(posedge clk or negedge nrst)
begin
	if (!nrst)
	begin
		pllOutDividerIn <= `OCPCL_OD_RST;
		pllFeedback     <= `OCPCL_F_RST;
		pllRefDiv       <= `OCPCL_R_RST;
	end
	else if (xlateReload)
	begin
		// load after reset and on change
		pllOutDividerIn <= lutOutDiv;
		pllFeedback     <= lutFeedback;
		pllRefDiv       <= lutRefDiv;
	end
end

// ----------------------------------------------------------------------
// Verification timers: main, internal, PLL
// ----------------------------------------------------------------------
// check enables: main oscillator, internal oscillator, PLL
assign checkEn[`OCPCL_FLT_MAIN]   = runCfg[`OCPCL_MAIN_CHK_BIT];
assign checkEn[`OCPCL_FLT_INT]    = runCfg[`OCPCL_INT_CHK_BIT];
assign checkEn[`OCPCL_FLT_PLL]    = runCfg[`OCPCL_PLL_CHK_BIT];

// ----------------------------------------------------------------------
// Alive ticks from the far side
// ----------------------------------------------------------------------
assign aliveTick[`OCPCL_FLT_MAIN] = mainOscTick;
assign aliveTick[`OCPCL_FLT_INT]  = intOscTick;
assign aliveTick[`OCPCL_FLT_PLL]  = pllTick;

// ----------------------------------------------------------------------
// Timer instances, one per source
// ----------------------------------------------------------------------
genvar gi;
generate
	for (gi = 0; gi < `OCPCL_NCHK; gi = gi + 1)
	begin : chk
		ocpcl_watch watch
		(
			.clk       (clk),
			.nrst      (nrst),
			.enable    (checkEn[gi]),
			.aliveTick (aliveTick[gi]),
			.fault     (faultPulse[gi])
		);
	end
endgenerate

// ----------------------------------------------------------------------
// Sticky faults, write one to clear; a new fault beats the clear
// ----------------------------------------------------------------------
always @*
begin
	next_clkFault = clkFault;
	if (wrStatus)
		next_clkFault = clkFault & ~regWdata[`OCPCL_NCHK-1:0];
	next_clkFault = next_clkFault | (faultPulse & checkEn);
end

always @(posedge clk or negedge nrst)
begin
	if (!nrst)
		clkFault <= {`OCPCL_NCHK{1'b0}};
	else
		clkFault <= next_clkFault;
end

// ----------------------------------------------------------------------
// Interrupt request: any recorded fault
// ----------------------------------------------------------------------
always @(posedge clk or negedge nrst)
begin
	if (!nrst)
		clkFailIrq <= 1'b0;
	else
		clkFailIrq <= |next_clkFault;
end

// ----------------------------------------------------------------------
// Read words, unused upper bits zero
// ----------------------------------------------------------------------
assign runCfgWord = {{(32-`OCPCL_RUNCFG_W){1'b0}}, runCfg};
assign statusWord = {{(32-`OCPCL_NCHK){1'b0}}, clkFault};
assign xlateWord[`OCPCL_OD_HI:`OCPCL_OD_LO] = pllOutDividerIn;
assign xlateWord[`OCPCL_F_HI:`OCPCL_F_LO]   = pllFeedback;
assign xlateWord[`OCPCL_R_HI:`OCPCL_R_LO]   = pllRefDiv;
assign xlateWord[31:16] = 16'h0000;

// ----------------------------------------------------------------------
// Read port: data in the cycle after the strobe
// ----------------------------------------------------------------------
always @*
begin
	next_regRdata = 32'h0000_0000;
	if (regRd)
	begin
		case (regAddr)
			`OCPCL_OFS_RUNCFG:
				next_regRdata = runCfgWord;
			`OCPCL_OFS_XLATE:
				next_regRdata = xlateWord;
			`OCPCL_OFS_STATUS:
				next_regRdata = statusWord;
			default:
				next_regRdata = 32'h0000_0000;
		endcase
	end
end

always @(posedge clk or negedge nrst)
begin
	if (!nrst)
		regRdata <= 32'h0000_0000;
	else
		regRdata <= next_regRdata;
end

endmodule // ocpcl_top

`default_nettype wire

// file: ocpcl_checker.sv
// Port-level assertions for the clock-source configuration block
`default_nettype none
`include "ocpcl_regs.vh"

module ocpcl_checker
(
	input wire logic                     clk,
	input wire logic                     nrst,
	input wire logic [`OCPCL_ADDR_W-1:0] regAddr,
	input wire logic [31:0]              regWdata,
	input wire logic                     regWr,
	input wire logic                     regRd,
	input wire logic [31:0]              regRdata,
	input wire logic                     mainOscOff,
	input wire logic                     intOscOff,
	input wire logic [1:0]               oscSourceSel,
	input wire logic                     pllPowerDown,
	input wire logic                     pllOutGateN,
	input wire logic                     pllRunning,
	input wire logic                     sysClkFromOsc,
	input wire logic [8:0]               pllFeedback,
	input wire logic [`OCPCL_NCHK-1:0]   clkFault,
	input wire logic                     clkFailIrq
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	wire cfgWr = regWr && regAddr == `OCPCL_OFS_RUNCFG;
	chk_main_off: assert property (cfgWr |-> ##2
		mainOscOff == $past(regWdata[0], 2)) else $error("main off bit");
	chk_int_off: assert property (cfgWr |-> ##2
		intOscOff == $past(regWdata[1], 2)) else $error("int off bit");
	chk_src_sel: assert property (cfgWr && regWdata[5:4] != 2'h3 |-> ##2
		oscSourceSel == $past(regWdata[5:4], 2)) else $error("source");
	chk_bypass_sel: assert property (cfgWr |-> ##2
		sysClkFromOsc == $past(regWdata[11], 2)) else $error("bypass");
	chk_pll_mode: assert property (pllPowerDown |-> !pllRunning)
		else $error("pll runs while powered down");
	chk_pll_normal: assert property (pllRunning ==
		(!pllPowerDown && !pllOutGateN)) else $error("pll mode decode");
	chk_src_keep: assert property (cfgWr && regWdata[5:4] == 2'h3 |->
		##2 $stable(oscSourceSel)) else $error("reserved source taken");
	chk_irq_or: assert property (clkFailIrq == (|clkFault))
		else $error("irq differs from faults");
	chk_xlate_load: assert property ($changed(pllFeedback) |->
		$past(cfgWr, 3) || $past(cfgWr, 2)) else $error("xlate change");
	chk_xlate_hi: assert property ($past(regRd) &&
		$past(regAddr) == `OCPCL_OFS_XLATE |-> regRdata[31:16] == 16'h0)
		else $error("xlate upper bits");
	chk_rd_idle: assert property (!$past(regRd) |-> regRdata == 32'h0)
		else $error("read data outside slot");
	cov_fault: cover property ($rose(clkFailIrq));
	cov_run: cover property ($rose(pllRunning));
	cov_xlate: cover property ($changed(pllFeedback));
endmodule // ocpcl_checker

bind ocpcl_top ocpcl_checker ocpcl_checker_inst (.clk(clk), .nrst(nrst),
	.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
	.regRdata(regRdata), .mainOscOff(mainOscOff), .intOscOff(intOscOff),
	.oscSourceSel(oscSourceSel), .pllPowerDown(pllPowerDown),
	.pllOutGateN(pllOutGateN),
	.pllRunning(pllRunning), .sysClkFromOsc(sysClkFromOsc),
	.pllFeedback(pllFeedback), .clkFault(clkFault), .clkFailIrq(clkFailIrq));
`default_nettype wire

// file: ocpcl_osc_model.sv
// Behavioural oscillators and PLL giving alive ticks
`default_nettype none

module ocpcl_osc_model
(
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic mainOscOff,
	input  wire logic intOscOff,
	input  wire logic pllPowerDown,
	input  wire logic pllOutGateN,
	output var  logic mainOscTick,
	output var  logic intOscTick,
	output var  logic pllTick
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------------------------------
	// Tick every fourth cycle while the source runs
	// ----------------------------------------------------------------
	logic [1:0] phase;
	always @(posedge clk or negedge nrst)
	begin
		if (!nrst) phase <= 2'h0;
		else phase <= phase + 2'h1;
	end
	assign mainOscTick = nrst && phase == 2'h0 && !mainOscOff;
	assign intOscTick = nrst && phase == 2'h0 && !intOscOff;
	assign pllTick = nrst && phase == 2'h0 && !pllPowerDown && !pllOutGateN;
endmodule // ocpcl_osc_model
`default_nettype wire

// file: ocpcl_tb_top.sv
// Self-checking bench for the clock-source configuration block
`default_nettype none
`include "ocpcl_regs.vh"
`define CHK(a, b) begin numChecks++; if ((a) !== (b)) begin errCount++; \
	$display("wrong value at %0t: got %h want %h", $time, a, b); end end

module ocpcl_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, nrst, regWr, regRd, mTick, iTick, pTick, mOff, iOff;
	logic pDown, gateN, running, bypass, irq;
	logic [11:0] regAddr;
	logic [31:0] regWdata, regRdata, d;
	logic [1:0]  src, od;
	logic [8:0]  fb;
	logic [4:0]  rdiv, rExp;
	logic [2:0]  fault;
	int errCount = 0, numChecks = 0;
	logic [8:0] fbTab [16] = '{9'h000, 9'h000, 9'h000, 9'h000, 9'h070,
		9'h06D, 9'h064, 9'h062, 9'h051, 9'h050, 9'h04E, 9'h0C8, 9'h041,
		9'h036, 9'h032, 9'h031};

	ocpcl_top ocpcl_top_inst (.clk(clk), .nrst(nrst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .mainOscTick(mTick), .intOscTick(iTick),
		.pllTick(pTick), .mainOscOff(mOff), .intOscOff(iOff),
		.oscSourceSel(src), .pllPowerDown(pDown), .pllOutGateN(gateN),
		.pllRunning(running), .sysClkFromOsc(bypass), .pllOutDividerIn(od),
		.pllFeedback(fb), .pllRefDiv(rdiv), .clkFault(fault),
		.clkFailIrq(irq));
	ocpcl_osc_model ocpcl_osc_model_inst (.clk(clk), .nrst(nrst),
		.mainOscOff(mOff), .intOscOff(iOff), .pllPowerDown(pDown),
		.pllOutGateN(gateN), .mainOscTick(mTick), .intOscTick(iTick),
		.pllTick(pTick));

	// ----------------------------------------------------------------
	// Bus tasks
	// ----------------------------------------------------------------
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= v;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] v);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1 v = regRdata;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic finalReport;
		$display("checks %0d mismatches %0d", numChecks, errCount);
		if (errCount == 0 && numChecks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial
	begin
		int i;
		nrst = 1'b0; regWr = 1'b0; regRd = 1'b0;
		regAddr = 12'h000; regWdata = 32'h0;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		rd(`OCPCL_OFS_RUNCFG, d); `CHK(d, 32'h00003AC0)
		rd(`OCPCL_OFS_XLATE, d); `CHK(d, 32'h00001903)
		`CHK({pDown, gateN, running}, 3'h6)
		$display("test reset done");
		for (i = 0; i < 16; i++)
		begin
			wr(`OCPCL_OFS_RUNCFG, 32'h3800 | (32'(i) << 6));
			idle(2);
			rd(`OCPCL_OFS_XLATE, d);
			rExp = (i < 4) ? 5'h00 : (i == 11) ? 5'h03 : 5'h01;
			`CHK(d, {18'h0, fbTab[i], rExp})
			`CHK({od, fb, rdiv}, {2'h0, fbTab[i], rExp})
			rd(`OCPCL_OFS_RUNCFG, d); `CHK(d, 32'h3800 | (32'(i) << 6))
		end
		$display("test crystal done");
		for (i = 0; i < 4; i++)
		begin
			wr(`OCPCL_OFS_RUNCFG, 32'h3AC0 | (32'(i) << 4));
			idle(2); `CHK(src, i < 3 ? i[1:0] : 2'h2)
		end
		wr(`OCPCL_OFS_RUNCFG, 32'h02C0);
		idle(2); `CHK({pDown, running, bypass}, 3'h2)
		wr(`OCPCL_OFS_RUNCFG, 32'h22C0);
		idle(2); `CHK({pDown, running, bypass}, 3'h4)
		$display("test mode done");
		wr(`OCPCL_OFS_RUNCFG, 32'h06CC);
		idle(250); `CHK(fault, 3'h0)
		wr(`OCPCL_OFS_RUNCFG, 32'h22C3);
		idle(250); `CHK({mOff, iOff, fault}, 5'h18)
		wr(`OCPCL_OFS_RUNCFG, 32'h26CF);
		for (i = 0; i < 400 && irq !== 1'b1; i++) idle(1);
		if (irq !== 1'b1)
		begin
			errCount++;
			$display("wrong value at %0t: no fault raised", $time);
			finalReport();
		end
		idle(3); `CHK(fault, 3'h7)
		rd(`OCPCL_OFS_STATUS, d); `CHK(d, 32'h7)
		wr(`OCPCL_OFS_RUNCFG, 32'h22C3);
		wr(`OCPCL_OFS_STATUS, 32'h7);
		rd(`OCPCL_OFS_STATUS, d); `CHK({d, irq}, 33'h0)
		$display("test checkers done");
		rd(12'h0FC, d); `CHK(d, 32'h0)
		wr(`OCPCL_OFS_XLATE, 32'hFFFFFFFF);
		rd(`OCPCL_OFS_XLATE, d); `CHK(d, 32'h00001903)
		$display("test access done");
		finalReport();
	end
endmodule // ocpcl_tb_top
`default_nettype wire
